// *** dv/sss_analog_src.sv ***
module sss_analog_src (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request from bench
  input  wire logic        req,
  input  wire logic [11:0] u_in,
  input  wire logic [11:0] c_in,
  input  wire logic [11:0] b_in,
  // digitized inputs
  output logic             sample_valid,
  output logic      [11:0] u_smp,
  output logic      [11:0] c_smp,
  output logic      [11:0] b_smp
);
  timeunit 1ns;
  timeprecision 1ps;
  // one sample per request; lines toggle outside the strobe so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      {u_smp, c_smp, b_smp} <= 36'h0;
    end else begin
      sample_valid <= req;
      if (req)
        {u_smp, c_smp, b_smp} <= {u_in, c_in, b_in};
      else
        {u_smp, c_smp, b_smp} <= ~{u_smp, c_smp, b_smp};
    end
  end
endmodule

// *** dv/sss_selector_monitor.sv ***
module sss_selector_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb answer side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // setpoint
  input wire logic [15:0] setpoint_freq,
  input wire logic        setpoint_reverse,
  input wire logic        setpoint_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb timing, exactly one wait state
  a_ready_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready missing after one wait state");
  a_ready_after_wait: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  // result qualifiers; outputs only move with the valid pulse
  a_valid_pulse: assert property (setpoint_valid |=> !setpoint_valid)
    else $error("setpoint_valid longer than one cycle");
  a_freq_holds: assert property (!setpoint_valid |-> $stable(setpoint_freq))
    else $error("setpoint_freq moved without valid");
  a_reverse_holds: assert property (!setpoint_valid |-> $stable(setpoint_reverse))
    else $error("setpoint_reverse moved without valid");
  c_unmapped: cover property (pslverr);
  c_reversed: cover property ($rose(setpoint_reverse));
  c_clamped: cover property (setpoint_valid && setpoint_freq == 16'h0);
endmodule
bind sss_selector sss_selector_monitor u_sss_selector_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .setpoint_freq(setpoint_freq), .setpoint_reverse(setpoint_reverse),
  .setpoint_valid(setpoint_valid)
);

// *** dv/tb_setpoint_source_selector.sv ***
module tb_setpoint_source_selector;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        req     = 1'b0;
  logic        pin     = 1'b0;
  logic [11:0] u_in    = 12'h0;
  logic [11:0] c_in    = 12'h0;
  logic [11:0] b_in    = 12'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_valid;
  logic [11:0] u_smp;
  logic [11:0] c_smp;
  logic [11:0] b_smp;
  logic [15:0] setpoint_freq;
  logic        setpoint_reverse;
  logic        setpoint_valid;
  int          err_count = 0;
  int          n_checks  = 0;

  always #20 pclk = ~pclk;

  sss_selector u_sss_selector (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .unipolar_voltage_input(u_smp), .current_loop_input(c_smp), .bipolar_voltage_input(b_smp),
    .analog_changeover_input(pin), .setpoint_freq(setpoint_freq), .setpoint_reverse(setpoint_reverse),
    .setpoint_valid(setpoint_valid)
  );
  sss_analog_src u_sss_analog_src (
    .pclk(pclk), .presetn(presetn), .req(req), .u_in(u_in), .c_in(c_in), .b_in(b_in),
    .sample_valid(sample_valid), .u_smp(u_smp), .c_smp(c_smp), .b_smp(b_smp)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request stands until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask

  task automatic send(input logic [11:0] u, input logic [11:0] c, input logic [11:0] b);
    @(posedge pclk);
    req  <= 1'b1;
    u_in <= u;
    c_in <= c;
    b_in <= b;
    @(posedge pclk);
    req <= 1'b0;
  endtask

  // pin settles through the synchroniser while the sample is queued
  task automatic mode(input logic ctl, input logic p, input logic [7:0] s, input logic [7:0] cb,
                      input logic [11:0] u, input logic [11:0] c, input logic [11:0] b,
                      input logic [15:0] f, input logic r);
    int n;
    wr(sss_pkg::OFF_CONTROL, {31'h0, ctl});
    wr(sss_pkg::OFF_CHANGEOVER_SEL, {24'h0, s});
    wr(sss_pkg::OFF_BIPOLAR_COMB, {24'h0, cb});
    pin <= p;
    send(u, c, b);
    n = 0;
    while (setpoint_valid !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) err_count++;
    chk({15'h0, setpoint_reverse, setpoint_freq}, {15'h0, r, f});
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog, well past the longest expected run
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), (i inside {[2:4]}) ? {16'h0, sss_pkg::GAIN_RST} : 32'h0, 1'b0);
    end
    rd(sss_pkg::OFF_FILTER_DEPTH, 32'h8, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    $display("test reset values done");
    wr(sss_pkg::OFF_GAIN_B, 32'hffff);
    rd(sss_pkg::OFF_GAIN_B, 32'hfffa, 1'b0);
    wr(sss_pkg::OFF_ZERO_C, 32'h199a);
    rd(sss_pkg::OFF_ZERO_C, 32'h1999, 1'b0);
    wr(sss_pkg::OFF_FILTER_DEPTH, 32'h20);
    rd(sss_pkg::OFF_FILTER_DEPTH, 32'h1e, 1'b0);
    wr(sss_pkg::OFF_FILTER_DEPTH, 32'h0);
    rd(sss_pkg::OFF_FILTER_DEPTH, 32'h1, 1'b0);
    $display("test limits done");
    wr(sss_pkg::OFF_GAIN_U, 32'h8000);
    wr(sss_pkg::OFF_ZERO_U, 32'h100);
    wr(sss_pkg::OFF_CHANGEOVER_SEL, 32'h1);
    wr(sss_pkg::OFF_INIT_CMD, 32'h1);
    rd(sss_pkg::OFF_CHANGEOVER_SEL, 32'h0, 1'b0);
    rd(sss_pkg::OFF_FILTER_DEPTH, 32'h8, 1'b0);
    rd(sss_pkg::OFF_GAIN_U, 32'h8000, 1'b0);
    rd(sss_pkg::OFF_ZERO_U, 32'h100, 1'b0);
    rd(sss_pkg::OFF_ZERO_C, 32'h1999, 1'b0);
    $display("test init done");
    // identity span so the frequency equals the trimmed magnitude
    wr(sss_pkg::OFF_SPAN_IN_MAX, 32'hffff);
    wr(sss_pkg::OFF_SPAN_F_END, 32'hffff);
    wr(sss_pkg::OFF_FILTER_DEPTH, 32'h1);
    mode(1'b1, 1'b0, 8'h00, 8'h00, 12'h300, 12'h100, 12'h080, 16'h400, 1'b0);
    // unit trims everywhere, else the limit-test leftovers skew the sums
    wr(sss_pkg::OFF_GAIN_U, 32'h4000);
    wr(sss_pkg::OFF_ZERO_U, 32'h0);
    wr(sss_pkg::OFF_GAIN_B, 32'h4000);
    wr(sss_pkg::OFF_ZERO_C, 32'h0);
    mode(1'b0, 1'b1, 8'h01, 8'h02, 12'h300, 12'h100, 12'hc00, 16'h400, 1'b0);
    mode(1'b1, 1'b0, 8'h01, 8'h00, 12'h300, 12'h100, 12'h080, 16'h300, 1'b0);
    mode(1'b1, 1'b1, 8'h00, 8'h00, 12'h300, 12'h100, 12'h080, 16'h100, 1'b0);
    mode(1'b1, 1'b1, 8'h01, 8'h00, 12'h300, 12'h100, 12'h080, 16'h080, 1'b0);
    mode(1'b1, 1'b1, 8'h00, 8'h01, 12'h300, 12'h100, 12'h080, 16'h180, 1'b0);
    mode(1'b1, 1'b0, 8'h01, 8'h01, 12'h300, 12'h100, 12'hc00, 16'h000, 1'b0);
    mode(1'b1, 1'b0, 8'h01, 8'h02, 12'h300, 12'h100, 12'hc00, 16'h100, 1'b1);
    mode(1'b1, 1'b1, 8'h01, 8'h02, 12'h300, 12'h100, 12'hc00, 16'h400, 1'b1);
    mode(1'b1, 1'b1, 8'h01, 8'h00, 12'h300, 12'h100, 12'hc00, 16'h000, 1'b0);
    $display("test source selection done");
    wr(sss_pkg::OFF_FILTER_DEPTH, 32'h2);
    send(12'h0c9, 12'h0, 12'h0);
    mode(1'b1, 1'b0, 8'h00, 8'h00, 12'h064, 12'h0, 12'h0, 16'h096, 1'b0);
    wr(sss_pkg::OFF_FILTER_DEPTH, 32'h1e);
    repeat (29) send(12'h0, 12'h0, 12'h0);
    mode(1'b1, 1'b0, 8'h00, 8'h00, 12'h3c0, 12'h0, 12'h0, 16'h020, 1'b0);
    $display("test filter done");
    // falling frequency span over an offset input range
    wr(sss_pkg::OFF_FILTER_DEPTH, 32'h1);
    wr(sss_pkg::OFF_SPAN_IN_MIN, 32'h100);
    wr(sss_pkg::OFF_SPAN_IN_MAX, 32'h500);
    wr(sss_pkg::OFF_SPAN_F_START, 32'h1000);
    wr(sss_pkg::OFF_SPAN_F_END, 32'h0);
    mode(1'b1, 1'b0, 8'h00, 8'h00, 12'h300, 12'h0, 12'h0, 16'h800, 1'b0);
    $display("test span done");
    tally_and_finish();
  end
endmodule

// *** inc/sss_pkg.sv ***
package sss_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CHANGEOVER_SEL = 8'h00;
  localparam logic [7:0] OFF_BIPOLAR_COMB   = 8'h04;
  localparam logic [7:0] OFF_GAIN_U         = 8'h08;
  localparam logic [7:0] OFF_GAIN_C         = 8'h0c;
  localparam logic [7:0] OFF_GAIN_B         = 8'h10;
  localparam logic [7:0] OFF_ZERO_U         = 8'h14;
  localparam logic [7:0] OFF_ZERO_C         = 8'h18;
  localparam logic [7:0] OFF_ZERO_B         = 8'h1c;
  localparam logic [7:0] OFF_CONTROL        = 8'h20;
  localparam logic [7:0] OFF_FILTER_DEPTH   = 8'h24;
  localparam logic [7:0] OFF_SPAN_IN_MIN    = 8'h28;
  localparam logic [7:0] OFF_SPAN_IN_MAX    = 8'h2c;
  localparam logic [7:0] OFF_SPAN_F_START   = 8'h30;
  localparam logic [7:0] OFF_SPAN_F_END     = 8'h34;
  localparam logic [7:0] OFF_INIT_CMD       = 8'h38;
  localparam logic [7:0] OFF_STATUS         = 8'h3c;

  // field positions
  localparam int CTRL_ASSIGNED_BIT = 0;
  localparam int INIT_GO_BIT       = 0;
  localparam int STAT_REVERSE_BIT  = 16;
  localparam int STAT_CHANGE_BIT   = 17;
  localparam int STAT_VALID_BIT    = 18;

  // selection codes
  localparam logic [7:0] SEL_TO_CURRENT = 8'h00;
  localparam logic [7:0] SEL_TO_BIPOLAR = 8'h01;
  localparam logic [7:0] COMB_ALONE     = 8'h00;
  localparam logic [7:0] COMB_ADD_FWD   = 8'h01;
  localparam logic [7:0] COMB_ADD_REV   = 8'h02;

  // reset values and limits
  localparam logic [7:0]  SEL_RST       = 8'h00;
  localparam logic [7:0]  COMB_RST      = 8'h00;
  localparam logic [15:0] GAIN_RST      = 16'h4000;
  localparam logic [15:0] ZERO_RST      = 16'h0000;
  localparam logic [15:0] GAIN_MAX      = 16'hfffa;
  localparam logic [15:0] ZERO_MAX      = 16'h1999;
  localparam logic [4:0]  DEPTH_MIN     = 5'h01;
  localparam logic [4:0]  DEPTH_MAX     = 5'h1e;
  localparam logic [4:0]  DEPTH_RST     = 5'h08;
  localparam logic [15:0] SPAN_MIN_RST  = 16'h0000;
  localparam logic [15:0] SPAN_MAX_RST  = 16'h0fff;
  localparam logic [15:0] F_START_RST   = 16'h0000;
  localparam logic [15:0] F_END_RST     = 16'h9c40;
  localparam logic [11:0] BIPOLAR_BIAS  = 12'h800;
  localparam int          GAIN_SHIFT    = 14;
  localparam logic [15:0] MAG_MAX       = 16'hffff;

  // sample and arithmetic widths
  localparam int SAMPLE_W = 12;
  localparam int SUM_W    = 17;
  localparam int NUM_CH   = 3;
  localparam logic [1:0] CH_U = 2'h0;
  localparam logic [1:0] CH_C = 2'h1;
  localparam logic [1:0] CH_B = 2'h2;

  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_AVG  = 4'b0010,
    ST_COMB = 4'b0100,
    ST_SPAN = 4'b1000
  } sss_state_e;
endpackage

// *** src/sss_divider.sv ***
module sss_divider (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // answer
  output logic      [31:0] quotient,
  output logic             done
);
  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [16:0] rem;
    logic [31:0] quo;
    logic [15:0] dsr;
    logic        done;
  } sss_div_s;

  sss_div_s st_ff;
  sss_div_s nxt_st;

  // restoring division, one quotient bit per cycle; slow but tiny
  always_comb begin
    logic [16:0] trial;
    trial  = 17'h00000;
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = 6'h20;
      nxt_st.rem  = 17'h00000;
      nxt_st.quo  = dividend;
      nxt_st.dsr  = divisor;
    end else if (st_ff.busy) begin
      trial      = {st_ff.rem[15:0], st_ff.quo[31]};
      nxt_st.quo = {st_ff.quo[30:0], 1'b0};
      if (trial >= {1'b0, st_ff.dsr}) begin
        nxt_st.rem    = trial - {1'b0, st_ff.dsr};
        nxt_st.quo[0] = 1'b1;
      end else begin
        nxt_st.rem = trial;
      end
      nxt_st.cnt = st_ff.cnt - 6'h01;
      if (st_ff.cnt == 6'h01) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign quotient = st_ff.quo;
  assign done     = st_ff.done;
endmodule

// *** src/sss_selector.sv ***
// Summary of operation
// - with no changeover function assigned the setpoint is the sum of the 0..+10 V unipolar input and the current input.
// - switching to another input or adding the bipolar input happens only when a digital input carries the changeover function.
// - select code 00 with the changeover input active moves the source to the current input.
// - select code 01 with the changeover input active moves the source to the bipolar input.
// - combine code 00 adds nothing to the selected source, code 01 adds the bipolar input without letting the sum reverse direction.
// - combine code 02 adds the bipolar input and lets a negative sum reverse rotation; with the bipolar input selected, codes 01 and 02 add nothing.
// - with the function assigned, changeover inactive gives the unipolar input, active gives current (00) or bipolar (01).
// - gain and zero trims keep their values when parameters are restored to defaults.
// - each input has a gain trim accepting 0 to 65530.
// - each input has a zero trim accepting 0 to 6553.
// - a configurable input span maps linearly onto a configurable frequency span.
// - the analog samples are smoothed by an adjustable filter before use.
// - the filter averages between 1 and 30 samples.
//
// Register access over APB and the address map were chosen for this implementation.
module sss_selector (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // digitized analog inputs, same clock
  input  wire logic        sample_valid,
  input  wire logic [11:0] unipolar_voltage_input,
  input  wire logic [11:0] current_loop_input,
  input  wire logic [11:0] bipolar_voltage_input,
  // changeover pin, asynchronous
  input  wire logic        analog_changeover_input,
  // frequency setpoint
  output logic [15:0]      setpoint_freq,
  output logic             setpoint_reverse,
  output logic             setpoint_valid
);
  typedef struct packed {
    logic                       sync1;
    logic                       sync2;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic [7:0]                 sel;
    logic [7:0]                 comb;
    logic [2:0][15:0]           gain;
    logic [2:0][15:0]           zero;
    logic                       assigned;
    logic [4:0]                 depth;
    logic [15:0]                in_min;
    logic [15:0]                in_max;
    logic [15:0]                f_start;
    logic [15:0]                f_end;
    logic [4:0]                 cnt;
    logic [2:0][16:0]           acc;
    logic [2:0][16:0]           hold;
    logic [2:0][11:0]           avg;
    logic [1:0]                 ch;
    sss_pkg::sss_state_e        state;
    logic                       div_go;
    logic [31:0]                div_num;
    logic [15:0]                div_den;
    logic                       span_neg;
    logic                       rev;
    logic                       rev_pend;
    logic [15:0]                freq;
    logic                       valid;
  } sss_sel_s;

  sss_sel_s    st_ff;
  sss_sel_s    nxt_st;
  logic [31:0] div_q;
  logic        div_done;

  // shared divider for averaging and span scaling
  sss_divider u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (st_ff.div_go),
    .dividend (st_ff.div_num),
    .divisor  (st_ff.div_den),
    .quotient (div_q),
    .done     (div_done)
  );

  // register read mux
  function automatic logic [31:0] rd_mux(input sss_sel_s s, input logic [7:0] a, output logic err);
    logic [31:0] d;
    d   = 32'h00000000;
    err = 1'b0;
    case (a)
      sss_pkg::OFF_CHANGEOVER_SEL: d[7:0] = s.sel;
      sss_pkg::OFF_BIPOLAR_COMB:   d[7:0] = s.comb;
      sss_pkg::OFF_GAIN_U:         d[15:0] = s.gain[sss_pkg::CH_U];
      sss_pkg::OFF_GAIN_C:         d[15:0] = s.gain[sss_pkg::CH_C];
      sss_pkg::OFF_GAIN_B:         d[15:0] = s.gain[sss_pkg::CH_B];
      sss_pkg::OFF_ZERO_U:         d[15:0] = s.zero[sss_pkg::CH_U];
      sss_pkg::OFF_ZERO_C:         d[15:0] = s.zero[sss_pkg::CH_C];
      sss_pkg::OFF_ZERO_B:         d[15:0] = s.zero[sss_pkg::CH_B];
      sss_pkg::OFF_CONTROL:        d[sss_pkg::CTRL_ASSIGNED_BIT] = s.assigned;
      sss_pkg::OFF_FILTER_DEPTH:   d[4:0] = s.depth;
      sss_pkg::OFF_SPAN_IN_MIN:    d[15:0] = s.in_min;
      sss_pkg::OFF_SPAN_IN_MAX:    d[15:0] = s.in_max;
      sss_pkg::OFF_SPAN_F_START:   d[15:0] = s.f_start;
      sss_pkg::OFF_SPAN_F_END:     d[15:0] = s.f_end;
      sss_pkg::OFF_INIT_CMD:       d = 32'h00000000;
      sss_pkg::OFF_STATUS: begin
        d[15:0] = s.freq;
        d[sss_pkg::STAT_REVERSE_BIT] = s.rev;
        d[sss_pkg::STAT_CHANGE_BIT]  = s.sync2;
        d[sss_pkg::STAT_VALID_BIT]   = s.valid;
      end
      default: err = 1'b1;
    endcase
    return d;
  endfunction

  // trimmed channel value: (avg - zero) * gain, unit gain at 2^GAIN_SHIFT
  function automatic logic signed [35:0] trim(input logic signed [12:0] v, input logic [15:0] g,
                                              input logic [15:0] z);
    logic signed [17:0] d;
    logic signed [35:0] p;
    d = 18'(v) - $signed({2'b00, z});
    p = 36'(d) * $signed({20'h00000, g});
    return p >>> sss_pkg::GAIN_SHIFT;
  endfunction

  always_comb begin
    logic               acc_mode;
    logic               wr;
    logic               rd_err;
    logic [31:0]        rd_d;
    logic [11:0]        smp [3];
    logic signed [35:0] tv [3];
    logic signed [35:0] main_v;
    logic signed [35:0] mag_s;
    logic [15:0]        mag;
    logic [15:0]        fdiff;
    logic [16:0]        sum_n;
    acc_mode = 1'b0;
    rd_err   = 1'b0;
    main_v   = 36'sh0;
    mag_s    = 36'sh0;
    mag      = 16'h0000;
    fdiff    = 16'h0000;
    sum_n    = 17'h00000;
    nxt_st   = st_ff;
    nxt_st.div_go = 1'b0;
    nxt_st.valid  = 1'b0;
    smp[sss_pkg::CH_U] = unipolar_voltage_input;
    smp[sss_pkg::CH_C] = current_loop_input;
    smp[sss_pkg::CH_B] = bipolar_voltage_input ^ sss_pkg::BIPOLAR_BIAS;  // to offset binary
    for (int i = 0; i < sss_pkg::NUM_CH; i++) begin
      tv[i] = 36'sh0;
    end

    // pin synchroniser, only sync2 is used
    nxt_st.sync1 = analog_changeover_input;
    nxt_st.sync2 = st_ff.sync1;

    // apb: pready answers one cycle into the access phase
    nxt_st.pready  = psel && penable && !st_ff.pready;
    rd_d           = rd_mux(st_ff, paddr, rd_err);
    nxt_st.pslverr = psel && penable && !st_ff.pready && rd_err;
    nxt_st.prdata  = (psel && penable && !st_ff.pready && !pwrite) ? rd_d : 32'h00000000;
    wr = psel && penable && st_ff.pready && pwrite && !st_ff.pslverr;
    if (wr) begin
      case (paddr)
        sss_pkg::OFF_CHANGEOVER_SEL: nxt_st.sel = pwdata[7:0];
        sss_pkg::OFF_BIPOLAR_COMB:   nxt_st.comb = pwdata[7:0];
        sss_pkg::OFF_GAIN_U, sss_pkg::OFF_GAIN_C, sss_pkg::OFF_GAIN_B: begin
          nxt_st.gain[(paddr - sss_pkg::OFF_GAIN_U) >> 2] =
            (pwdata[15:0] > sss_pkg::GAIN_MAX) ? sss_pkg::GAIN_MAX : pwdata[15:0];
        end
        sss_pkg::OFF_ZERO_U, sss_pkg::OFF_ZERO_C, sss_pkg::OFF_ZERO_B: begin
          nxt_st.zero[(paddr - sss_pkg::OFF_ZERO_U) >> 2] =
            (pwdata[15:0] > sss_pkg::ZERO_MAX) ? sss_pkg::ZERO_MAX : pwdata[15:0];
        end
        sss_pkg::OFF_CONTROL:      nxt_st.assigned = pwdata[sss_pkg::CTRL_ASSIGNED_BIT];
        sss_pkg::OFF_FILTER_DEPTH: begin
          if (pwdata[7:0] > {3'b000, sss_pkg::DEPTH_MAX}) begin
            nxt_st.depth = sss_pkg::DEPTH_MAX;
          end else if (pwdata[4:0] < sss_pkg::DEPTH_MIN) begin
            nxt_st.depth = sss_pkg::DEPTH_MIN;
          end else begin
            nxt_st.depth = pwdata[4:0];
          end
          nxt_st.cnt = 5'h00;
          nxt_st.acc = '0;
        end
        sss_pkg::OFF_SPAN_IN_MIN:  nxt_st.in_min = pwdata[15:0];
        sss_pkg::OFF_SPAN_IN_MAX:  nxt_st.in_max = pwdata[15:0];
        sss_pkg::OFF_SPAN_F_START: nxt_st.f_start = pwdata[15:0];
        sss_pkg::OFF_SPAN_F_END:   nxt_st.f_end = pwdata[15:0];
        sss_pkg::OFF_INIT_CMD: begin
          // defaults restored; trims deliberately left alone
          if (pwdata[sss_pkg::INIT_GO_BIT]) begin
            nxt_st.sel      = sss_pkg::SEL_RST;
            nxt_st.comb     = sss_pkg::COMB_RST;
            nxt_st.assigned = 1'b0;
            nxt_st.depth    = sss_pkg::DEPTH_RST;
            nxt_st.in_min   = sss_pkg::SPAN_MIN_RST;
            nxt_st.in_max   = sss_pkg::SPAN_MAX_RST;
            nxt_st.f_start  = sss_pkg::F_START_RST;
            nxt_st.f_end    = sss_pkg::F_END_RST;
            nxt_st.cnt      = 5'h00;
            nxt_st.acc      = '0;
          end
        end
        default: ;
      endcase
    end

    // block average: sum depth samples, a batch is dropped while the sequencer is busy
    if (sample_valid && !wr) begin
      acc_mode = (st_ff.cnt + 5'h01 == st_ff.depth);
      for (int i = 0; i < sss_pkg::NUM_CH; i++) begin
        sum_n = st_ff.acc[i] + {5'h00, smp[i]};
        nxt_st.acc[i] = acc_mode ? 17'h00000 : sum_n;
        if (acc_mode) begin
          nxt_st.hold[i] = sum_n;
        end
      end
      nxt_st.cnt = acc_mode ? 5'h00 : st_ff.cnt + 5'h01;
      if (acc_mode && st_ff.state == sss_pkg::ST_IDLE) begin
        nxt_st.state   = sss_pkg::ST_AVG;
        nxt_st.ch      = sss_pkg::CH_U;
        nxt_st.div_go  = 1'b1;
        nxt_st.div_den = {11'h000, st_ff.depth};
        nxt_st.div_num = {15'h0000, st_ff.acc[sss_pkg::CH_U] + {5'h00, smp[sss_pkg::CH_U]}};  // unipolar first
      end
    end

    case (st_ff.state)
      sss_pkg::ST_IDLE: ;
      sss_pkg::ST_AVG: begin
        // divide each channel sum by depth in turn
        if (div_done) begin
          nxt_st.avg[st_ff.ch] = div_q[11:0];
          if (st_ff.ch == sss_pkg::CH_B) begin
            nxt_st.state = sss_pkg::ST_COMB;
          end else begin
            nxt_st.ch      = st_ff.ch + 2'h1;
            nxt_st.div_go  = 1'b1;
            nxt_st.div_num = {15'h0000, st_ff.hold[st_ff.ch + 2'h1]};
          end
        end
      end
      sss_pkg::ST_COMB: begin
        tv[sss_pkg::CH_U] = trim({1'b0, st_ff.avg[sss_pkg::CH_U]},
                                 st_ff.gain[sss_pkg::CH_U], st_ff.zero[sss_pkg::CH_U]);
        tv[sss_pkg::CH_C] = trim({1'b0, st_ff.avg[sss_pkg::CH_C]},
                                 st_ff.gain[sss_pkg::CH_C], st_ff.zero[sss_pkg::CH_C]);
        tv[sss_pkg::CH_B] = trim($signed({1'b0, st_ff.avg[sss_pkg::CH_B]}) - $signed({1'b0, sss_pkg::BIPOLAR_BIAS}),
                                 st_ff.gain[sss_pkg::CH_B], st_ff.zero[sss_pkg::CH_B]);
        // source selection
        if (!st_ff.assigned) begin
          main_v = tv[sss_pkg::CH_U] + tv[sss_pkg::CH_C];
        end else if (!st_ff.sync2) begin
          main_v = tv[sss_pkg::CH_U];
        end else if (st_ff.sel == sss_pkg::SEL_TO_BIPOLAR) begin
          main_v = tv[sss_pkg::CH_B];
        end else begin
          main_v = tv[sss_pkg::CH_C];
        end
        // bipolar addition only in the unipolar or current source cases
        if (st_ff.assigned && !(st_ff.sync2 && st_ff.sel == sss_pkg::SEL_TO_BIPOLAR) &&
            (st_ff.comb == sss_pkg::COMB_ADD_FWD || st_ff.comb == sss_pkg::COMB_ADD_REV)) begin
          main_v = main_v + tv[sss_pkg::CH_B];
        end
        // sign handling: only code 02 may reverse
        if (main_v < 0 && st_ff.comb == sss_pkg::COMB_ADD_REV && st_ff.assigned) begin
          nxt_st.rev_pend = 1'b1;
          mag_s      = -main_v;
        end else begin
          nxt_st.rev_pend = 1'b0;
          mag_s      = (main_v < 0) ? 36'sh0 : main_v;
        end
        mag = (mag_s > $signed({20'h00000, sss_pkg::MAG_MAX})) ? sss_pkg::MAG_MAX : mag_s[15:0];
        // span mapping: clamp outside the input span, else scale linearly
        nxt_st.span_neg = st_ff.f_end < st_ff.f_start;
        fdiff = nxt_st.span_neg ? st_ff.f_start - st_ff.f_end : st_ff.f_end - st_ff.f_start;
        if (mag <= st_ff.in_min || st_ff.in_max <= st_ff.in_min) begin
          nxt_st.freq  = (st_ff.in_max <= st_ff.in_min) ? st_ff.f_end : st_ff.f_start;
          nxt_st.valid = 1'b1;
          nxt_st.state = sss_pkg::ST_IDLE;
        end else if (mag >= st_ff.in_max) begin
          nxt_st.freq  = st_ff.f_end;
          nxt_st.valid = 1'b1;
          nxt_st.state = sss_pkg::ST_IDLE;
        end else begin
          nxt_st.div_go  = 1'b1;
          nxt_st.div_num = (mag - st_ff.in_min) * fdiff;
          nxt_st.div_den = st_ff.in_max - st_ff.in_min;
          nxt_st.state   = sss_pkg::ST_SPAN;
        end
      end
      sss_pkg::ST_SPAN: begin
        if (div_done) begin
          nxt_st.freq  = st_ff.span_neg ? st_ff.f_start - div_q[15:0] : st_ff.f_start + div_q[15:0];
          nxt_st.valid = 1'b1;
          nxt_st.state = sss_pkg::ST_IDLE;
        end
      end
      default: nxt_st.state = sss_pkg::ST_IDLE;
    endcase
    if (nxt_st.valid) begin  // direction moves only with valid, not while the span divide runs
      nxt_st.rev = nxt_st.rev_pend;
    end
  end

  // single state register; trims reset only here, never by the init command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.state   <= sss_pkg::ST_IDLE;
      st_ff.sel     <= sss_pkg::SEL_RST;
      st_ff.comb    <= sss_pkg::COMB_RST;
      st_ff.gain    <= {3{sss_pkg::GAIN_RST}};
      st_ff.zero    <= {3{sss_pkg::ZERO_RST}};
      st_ff.depth   <= sss_pkg::DEPTH_RST;
      st_ff.in_min  <= sss_pkg::SPAN_MIN_RST;
      st_ff.in_max  <= sss_pkg::SPAN_MAX_RST;
      st_ff.f_start <= sss_pkg::F_START_RST;
      st_ff.f_end   <= sss_pkg::F_END_RST;
      st_ff.div_den <= {11'h000, sss_pkg::DEPTH_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata           = st_ff.prdata;
  assign pready           = st_ff.pready;
  assign pslverr          = st_ff.pslverr;
  assign setpoint_freq    = st_ff.freq;
  assign setpoint_reverse = st_ff.rev;
  assign setpoint_valid   = st_ff.valid;
endmodule
